// ### tb/acs_core_model.sv
/*
 * Stand-in for the analog sample-and-hold and converter core.
 * Assumes the sequencer pulses conv_start_pulse once per conversion
 * and reads core_result while the sampler is cut off.
 */
`timescale 1ns/1ns
`default_nettype none

module acs_core_model
   import acs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sample_connect,
   input wire logic conv_start_pulse,
   input wire logic [9:0] target,
   output logic [9:0] core_result,
   output var logic rc_osc
);
   // ************************************
   // core behaviour
   // ************************************
   logic [9:0] held_reg;

   // rc source runs free, unrelated in phase to ref_clk
   initial rc_osc = 1'b0;
   always #37 rc_osc = ~rc_osc;

   // the held value is frozen when the conversion is launched
   always_ff @(posedge ref_clk) begin
      if (conv_start_pulse) begin
         held_reg <= target;
      end
   end

   // no valid result while sampling, so show the inverse
   assign core_result = sample_connect ? ~held_reg : held_reg;
endmodule

`default_nettype wire

// ### tb/tb_top.sv
/*
 * Self-checking bench for the acquisition/conversion sequencer.
 * Assumes acs_core_model stands in for the analog core.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top
   import acs_pkg::*;
;
   // ************************************
   // signals and instances
   // ************************************
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic module_enable = 1'b0;
   logic start_set = 1'b0;
   logic start_clear = 1'b0;
   logic flag_clear = 1'b0;
   acs_cfg_t cfg = '0;
   logic result_write = 1'b0;
   logic [9:0] result_wdata = 10'h000;
   logic [9:0] target = 10'h000;
   logic [9:0] last = 10'h2C7;
   logic rc_osc;
   logic [9:0] core_result;
   logic start_bit;
   logic conv_complete_flag;
   logic sample_connect;
   logic conv_start_pulse;
   logic [7:0] result_high_byte;
   logic [7:0] result_low_byte;
   int num_errors = 0;
   int total_checks = 0;
   int n;
   int div_tab[6] = '{2, 4, 8, 16, 32, 64};
   logic [2:0] cs_tab[6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
   int acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

   always #5 ref_clk = ~ref_clk;

   acs_sequencer i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .module_enable(module_enable), .start_set(start_set),
      .start_clear(start_clear), .flag_clear(flag_clear), .cfg(cfg),
      .rc_osc(rc_osc), .core_result(core_result),
      .result_write(result_write), .result_wdata(result_wdata),
      .start_bit(start_bit), .conv_complete_flag(conv_complete_flag),
      .result_high_byte(result_high_byte),
      .result_low_byte(result_low_byte), .sample_connect(sample_connect),
      .conv_start_pulse(conv_start_pulse));

   acs_core_model i_core (.ref_clk(ref_clk), .sample_connect(sample_connect),
      .conv_start_pulse(conv_start_pulse), .target(target),
      .core_result(core_result), .rc_osc(rc_osc));

   // ************************************
   // shared tasks
   // ************************************
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // outputs are read at the falling edge, well clear of updates
   task automatic step(int k);
      repeat (k) @(negedge ref_clk);
   endtask

   // one-clock strobe: 0 start, 1 abort, 2 flag clear, 3 result write
   task automatic strobe(int which);
      @(posedge ref_clk);
      start_set <= (which == 0);
      start_clear <= (which == 1);
      flag_clear <= (which == 2);
      result_write <= (which == 3);
      @(posedge ref_clk);
      {start_set, start_clear, flag_clear, result_write} <= 4'h0;
      step(1);
   endtask

   // full conversion; div 0 means rc source, conversion and hold timing then unchecked
   task automatic run(logic [2:0] acq, logic [2:0] cs, int apd, int div,
                      logic [9:0] val);
      @(posedge ref_clk);
      cfg <= {acq, cs}; // configured before start
      target <= val; // new input is set before the start, held at conv_start_pulse
      strobe(0);
      check("start_set", start_bit, 1'b1);
      n = 0;
      while (conv_start_pulse !== 1'b1 && n < 2000) begin
         check("sampling", sample_connect, 1'b1);
         step(1);
         n++;
      end
      // rc ticks come every seven or eight cycles, unaligned to the start
      check("acq_len", div > 0 ? (n >= apd*div+1 && n <= apd*div+3) :
         (n >= apd*5 && n <= apd*9+4), 1'b1);
      check("sample_off", sample_connect, 1'b0);
      n = 0;
      while (conv_complete_flag !== 1'b1 && n < 5000) begin
         check("start_busy", start_bit, 1'b1);
         step(1);
         n++;
      end
      if (div > 0) begin
         check("conv_len", n >= 11*div && n <= 11*div+1, 1'b1);
      end
      check("start_done", start_bit, 1'b0);
      check("res_hi", result_high_byte, {6'h00, val[9:8]});
      check("res_lo", result_low_byte, val[7:0]);
      last = val;
      n = 0;
      while (sample_connect !== 1'b1 && n < 2000) begin
         step(1);
         n++;
      end
      if (div > 0) begin
         check("hold_len", n >= 3*div-1 && n <= 3*div+2, 1'b1);
      end
      strobe(2); // flag cleared before the next start
      check("flag_clr", conv_complete_flag, 1'b0);
   endtask

   // abort during acquisition or conversion leaves the result alone
   task automatic abort_run(bit late);
      @(posedge ref_clk);
      cfg <= {3'h7, 3'h0};
      target <= ~last;
      strobe(0);
      n = 0;
      while (late && conv_start_pulse !== 1'b1 && n < 200) begin
         step(1);
         n++;
      end
      step(4);
      strobe(1);
      step(40);
      check("abort_go", start_bit, 1'b0);
      check("abort_flag", conv_complete_flag, 1'b0);
      check("abort_hi", result_high_byte, {6'h00, last[9:8]});
      check("abort_lo", result_low_byte, last[7:0]);
   endtask

   // ************************************
   // test sequence
   // ************************************
   initial begin
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      step(1);
      check("rst_start", start_bit, 1'b0);
      check("rst_flag", conv_complete_flag, 1'b0);
      check("rst_sample", sample_connect, 1'b1);
      @(posedge ref_clk);
      result_wdata <= 10'h2C7;
      strobe(3); // result bytes only change by write or completion
      check("wr_hi", result_high_byte, 8'h02);
      check("wr_lo", result_low_byte, 8'hC7);
      strobe(0); // start is ignored while the module is off
      step(2);
      check("off_start", start_bit, 1'b0);
      @(posedge ref_clk);
      module_enable <= 1'b1; // enable last, after setup
      for (int i = 0; i < 6; i++) begin
         run(3'h0, cs_tab[i], 0, div_tab[i], 10'h155 + 10'(i*67));
      end
      for (int i = 1; i < 8; i++) begin
         run(3'(i), 3'h0, acq_tab[i], 2, 10'h2AA - 10'(i*29));
      end
      run(3'h0, 3'h3, 0, 0, 10'h3FF);
      run(3'h2, 3'h7, 4, 0, 10'h001);
      abort_run(1'b0);
      abort_run(1'b1);
      close_out();
   end

   // watchdog: the sequence needs well under 50000 cycles
   initial begin
      #500000;
      num_errors++;
      close_out();
   end
endmodule

`default_nettype wire

// ### verilog/acs_pkg.sv
/*
 * Package for the converter acquisition/conversion sequencer: state
 * encoding, configuration carrier, timing constants and field values.
 * Assumes a single 100 MHz ref_clk serves as the oscillator period.
 */
`default_nettype none

package acs_pkg;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int unsigned ACS_CLK_MHZ = 100;
   localparam logic [3:0] ACS_CONV_PERIODS = 4'hB;  // 11 bit periods
   localparam logic [3:0] ACS_HOLD_PERIODS = 4'h3;  // wait after a conversion
   localparam int ACS_RES_BITS = 10;

   // ***************************************************************
   // field values
   // ***************************************************************
   localparam logic [2:0] ACS_ACQ_NONE = 3'h0;
   localparam logic [1:0] ACS_CLK_RC_LOW = 2'h3;   // x11 picks RC source
   localparam logic [5:0] ACS_DIV_RESET = 6'h00;
   localparam logic [3:0] ACS_CNT_RESET = 4'h0;
   localparam logic [4:0] ACS_ACQ_RESET = 5'h00;

   // ***************************************************************
   // types
   // ***************************************************************
   // gray along idle -> acquire -> convert -> hold -> idle
   typedef enum logic [1:0] {
      ACS_IDLE = 2'b00,
      ACS_ACQ = 2'b01,
      ACS_CONV = 2'b11,
      ACS_HOLD = 2'b10
   } acs_state_t;

   typedef struct packed {
      logic [2:0] acq_time_select;
      logic [2:0] conv_clock_select;
   } acs_cfg_t;

endpackage

`default_nettype wire

// ### verilog/acs_sequencer.sv
/*
 * Acquisition and conversion sequencer for a 10-bit successive
 * approximation converter: start bit, automatic acquisition timing,
 * conversion clock divider, completion flag and result bytes.
 * Assumes control inputs come from logic on ref_clk, the analog core
 * presents its result on core_result at the end of a conversion, and
 * rc_osc is a free-running clock from another domain.
 */
// Contract
// - power-on reset leaves the result bytes untouched until loaded.
// - at least three bit periods of hold-off before the next acquisition; after an abort the divider runs on, so the first period can be short.
// - acquisition select is applied on every setting of the start bit.
// - zero acquisition select means start ends sampling and converts.
// - nonzero select samples 2,4,6,8,12,16 or 20 periods then converts itself.
// - completion clears start bit and sets flag; sampling resumes after the hold-off.
// - no status tells acquisition from conversion; start bit covers both.
// - a conversion takes exactly eleven bit periods.
// - clock select maps to 2,4,8,16,32,64 oscillator periods or RC.
// - result bytes load in the same step as start clear and flag set.
`timescale 1ns/1ns
`default_nettype none

module acs_sequencer
   import acs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic module_enable,
   input wire logic start_set,
   input wire logic start_clear,
   input wire logic flag_clear,
   input wire acs_cfg_t cfg,
   input wire logic rc_osc,
   input wire logic [9:0] core_result,
   input wire logic result_write,
   input wire logic [9:0] result_wdata,
   output logic start_bit,
   output logic conv_complete_flag,
   output logic [7:0] result_high_byte,
   output logic [7:0] result_low_byte,
   output logic sample_connect,
   output logic conv_start_pulse
);

   // ***************************************************************
   // functions
   // ***************************************************************
   // last divider count: period doubles with each rank of the select
   function automatic logic [5:0] div_last(input logic [2:0] sel);
      div_last = 6'((7'h02 << {sel[1:0], sel[2]}) - 7'h01);
   endfunction

   // acquisition length: steps of two, then steps of four from eight
   function automatic logic [4:0] acq_periods(input logic [2:0] sel);
      acq_periods = {1'b0, sel, 1'b0} + {2'b00, sel[1:0] & {2{sel[2]}}, 1'b0};
   endfunction

   // ***************************************************************
   // declarations
   // ***************************************************************
   acs_state_t state_reg;
   logic [5:0] div_reg;
   logic [4:0] acq_cnt_reg;
   logic [3:0] per_cnt_reg;
   logic rc_meta_reg;
   logic rc_sync_reg;
   logic rc_prev_reg;
   logic use_rc;
   logic tad_tick;
   logic launch;
   logic zero_acq;
   logic conv_done;
   logic abort;

   // ***************************************************************
   // bit period tick
   // ***************************************************************
   // rc source crosses in on two flops before the edge detector
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rc_meta_reg <= 1'b0;
         rc_sync_reg <= 1'b0;
         rc_prev_reg <= 1'b0;
      end else begin
         rc_meta_reg <= rc_osc;
         rc_sync_reg <= rc_meta_reg;
         rc_prev_reg <= rc_sync_reg;
      end
   end

   assign use_rc = (cfg.conv_clock_select[1:0] == ACS_CLK_RC_LOW);

   // divider restarts on leaving idle so periods align with the start
   always_ff @(posedge ref_clk) begin
      if (!reset_n || state_reg == ACS_IDLE || tad_tick) begin
         div_reg <= ACS_DIV_RESET;
      end else begin
         div_reg <= div_reg + 6'h01;
      end
   end

   // rc ticks cannot be aligned; first rc period may be short
   assign tad_tick = (state_reg != ACS_IDLE) &&
      (use_rc ? (rc_sync_reg && !rc_prev_reg)
              : (div_reg == div_last(cfg.conv_clock_select)));

   // ***************************************************************
   // sequencing
   // ***************************************************************
   assign launch = (state_reg == ACS_IDLE) && start_bit && module_enable;
   assign zero_acq = (cfg.acq_time_select == ACS_ACQ_NONE);
   assign conv_done = (state_reg == ACS_CONV) && tad_tick &&
      (per_cnt_reg == 4'h1) && start_bit;
   assign abort = (state_reg == ACS_ACQ || state_reg == ACS_CONV) &&
      (!start_bit || !module_enable);

   // phase machine; abort also passes through the hold-off
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_reg <= ACS_IDLE;
      end else begin
         case (state_reg)
            ACS_IDLE: begin
               if (launch) begin
                  state_reg <= zero_acq ? ACS_CONV : ACS_ACQ;
               end
            end
            ACS_ACQ: begin
               if (abort) begin
                  state_reg <= ACS_HOLD;
               end else if (tad_tick && acq_cnt_reg == 5'h01) begin
                  state_reg <= ACS_CONV;
               end
            end
            ACS_CONV: begin
               if (abort || conv_done) begin
                  state_reg <= ACS_HOLD;
               end
            end
            ACS_HOLD: begin
               if (tad_tick && per_cnt_reg == 4'h1) begin
                  state_reg <= ACS_IDLE;
               end
            end
            default: state_reg <= ACS_IDLE;
         endcase
      end
   end

   // acquisition down-counter, loaded from the select on each start
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         acq_cnt_reg <= ACS_ACQ_RESET;
      end else if (launch) begin
         acq_cnt_reg <= acq_periods(cfg.acq_time_select);
      end else if (state_reg == ACS_ACQ && tad_tick) begin
         acq_cnt_reg <= acq_cnt_reg - 5'h01;
      end
   end

   // period counter shared by conversion and hold-off
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         per_cnt_reg <= ACS_CNT_RESET;
      end else if (abort || conv_done) begin
         per_cnt_reg <= ACS_HOLD_PERIODS;
      end else if ((launch && zero_acq) || (state_reg == ACS_ACQ &&
            tad_tick && acq_cnt_reg == 5'h01)) begin
         per_cnt_reg <= ACS_CONV_PERIODS;
      end else if (tad_tick && per_cnt_reg != ACS_CNT_RESET) begin
         per_cnt_reg <= per_cnt_reg - 4'h1;
      end
   end

   // conversion start strobe to the analog core
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         conv_start_pulse <= 1'b0;
      end else begin
         conv_start_pulse <= !abort && ((launch && zero_acq) ||
            (state_reg == ACS_ACQ && tad_tick &&
             acq_cnt_reg == 5'h01));
      end
   end

   // sampler stays connected except while converting or holding off
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sample_connect <= 1'b1;
      end else begin
         sample_connect <= (state_reg == ACS_IDLE && !(launch && zero_acq))
            || (state_reg == ACS_ACQ && !(tad_tick &&
            acq_cnt_reg == 5'h01)) || (state_reg == ACS_HOLD &&
            tad_tick && per_cnt_reg == 4'h1);
      end
   end

   // ***************************************************************
   // software-visible bits
   // ***************************************************************
   // start bit: only set with the module on; done and abort clear it
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         start_bit <= 1'b0;
      end else if (conv_done || !module_enable || start_clear) begin
         start_bit <= 1'b0;
      end else if (start_set) begin
         start_bit <= 1'b1;
      end
   end

   // completion flag: hardware set wins over a same-cycle clear
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         conv_complete_flag <= 1'b0;
      end else if (conv_done) begin
         conv_complete_flag <= 1'b1;
      end else if (flag_clear) begin
         conv_complete_flag <= 1'b0;
      end
   end

   // result bytes carry no reset so they survive any reset unchanged
   always_ff @(posedge ref_clk) begin
      if (conv_done) begin
         result_high_byte <= {6'h00, core_result[9:8]};
         result_low_byte <= core_result[7:0];
      end else if (result_write) begin
         result_high_byte <= {6'h00, result_wdata[9:8]};
         result_low_byte <= result_wdata[7:0];
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   logic [4:0] chk_ticks_reg;
   always_ff @(posedge ref_clk) begin
      if (!reset_n || state_reg != $past(state_reg)) begin
         chk_ticks_reg <= {4'h0, tad_tick};
      end else if (tad_tick) begin
         chk_ticks_reg <= chk_ticks_reg + 5'h01;
      end
   end

   sequence s_done;
      conv_done;
   endsequence
   sequence s_fast_start;
      launch && zero_acq && !abort;
   endsequence

   chk_done_flag_set: assert property (@(posedge ref_clk)
      disable iff (!reset_n) s_done |=> conv_complete_flag && !start_bit)
      else $error("completion did not set flag and clear start");
   chk_result_load: assert property (@(posedge ref_clk)
      disable iff (!reset_n) s_done |=>
      {result_high_byte[1:0], result_low_byte} == $past(core_result))
      else $error("result not loaded on completion");
   chk_zero_acq_start: assert property (@(posedge ref_clk)
      disable iff (!reset_n) s_fast_start |=>
      conv_start_pulse && !sample_connect && state_reg == ACS_CONV)
      else $error("zero acquisition did not convert at once");
   chk_conv_length: assert property (@(posedge ref_clk)
      disable iff (!reset_n) s_done |=> chk_ticks_reg == 5'h0B)
      else $error("conversion not eleven periods");
   chk_hold_length: assert property (@(posedge ref_clk)
      disable iff (!reset_n) state_reg == ACS_HOLD ##1
      state_reg == ACS_IDLE |-> chk_ticks_reg == 5'h03)
      else $error("hold-off not three periods");
   chk_acq_length: assert property (@(posedge ref_clk)
      disable iff (!reset_n) state_reg == ACS_ACQ ##1
      state_reg == ACS_CONV |-> conv_start_pulse &&
      chk_ticks_reg == acq_periods(cfg.acq_time_select))
      else $error("acquisition length wrong");
   chk_start_covers: assert property (@(posedge ref_clk)
      disable iff (!reset_n) (state_reg == ACS_ACQ ||
      state_reg == ACS_CONV) && !$past(start_clear) &&
      $past(module_enable) |-> start_bit)
      else $error("start bit dropped during a phase");
   chk_div_two: assert property (@(posedge ref_clk)
      disable iff (!reset_n) state_reg == ACS_ACQ &&
      cfg.conv_clock_select == 3'b000 && $stable(cfg) && !tad_tick
      |-> ##1 tad_tick || state_reg != ACS_ACQ)
      else $error("divide-by-two tick missing");
   chk_acq_countdown: assert property (@(posedge ref_clk)
      disable iff (!reset_n) conv_start_pulse |->
      acq_cnt_reg == 5'h00)
      else $error("conversion started before count reached zero");

endmodule

`default_nettype wire
